//--- core/pmbus_config_nvm_bank.sv
// configuration register bank with nonvolatile_store load, store and restore
module pmbus_config_nvm_bank
  import pmbus_cfg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire cmd_req_s i_cmd,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output logic o_refused,
  output logic o_busy,
  output cfg_s o_cfg
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] regs_q [NUM_REGS];
  // nonvolatile_store holds the factory table until a store overwrites it;
  // set at declaration so the store walk stays the only process writing it
  logic [15:0] nvm [NUM_REGS] = RST_TAB;
  seq_state_e state_q;
  seq_state_e state_d;
  logic [IDX_W-1:0] idx_q;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic refused_q;
  logic busy_q;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic [NUM_REGS-1:0] hit_vec;
  logic [IDX_W-1:0] hit_idx;
  wire idle = (state_q == ST_IDLE);
  wire req = i_cmd.valid;
  wire is_reg = |hit_vec;
  wire is_store = (i_cmd.code == CODE_STORE_ALL) || (i_cmd.code == CODE_STORE_USER_ALL);
  wire is_restore = (i_cmd.code == CODE_RESTORE_ALL);
  wire locked = (regs_q[IDX_WRITE_LOCK][7:0] != 8'h00);
  // the lock register itself stays writable, otherwise it could never be cleared
  wire wr_allowed = !locked || (hit_idx == IDX_WRITE_LOCK);
  wire do_read = req && idle && is_reg && !i_cmd.write;
  wire do_write = req && idle && is_reg && i_cmd.write && wr_allowed;
  wire start_store = req && idle && i_cmd.write && is_store;
  wire start_restore = req && idle && i_cmd.write && is_restore;
  wire accepted = do_read || do_write || start_store || start_restore;
  wire last = (idx_q == LAST_IDX);
  wire copy_in = (state_q == ST_LOAD) || (state_q == ST_RESTORE);

  // one comparator per table entry
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : g_hit
      assign hit_vec[g] = (i_cmd.code == CODE_TAB[g]);
    end
  endgenerate

  // codes are unique, so at most one bit of the vector is set
  always_comb begin
    hit_idx = '0;
    for (int k = 0; k < NUM_REGS; k++) begin
      if (hit_vec[k]) begin
        hit_idx = IDX_W'(k);
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // reset starts in the load walk so nothing acts on unloaded settings
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_LOAD: begin
        if (last) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (start_store) begin
          state_d = ST_STORE;
        end else if (start_restore) begin
          state_d = ST_RESTORE;
        end
      end
      ST_STORE, ST_RESTORE: begin
        if (last) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_LOAD;
      idx_q <= '0;
    end else begin
      state_q <= state_d;
      idx_q <= (state_d == ST_IDLE || state_q == ST_IDLE) ? '0 : idx_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // operating registers
  // ----------------------------------------------------------------
  // reset values are the factory table; the power-up walk then overlays the store
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int k = 0; k < NUM_REGS; k++) begin
        regs_q[k] <= RST_TAB[k];
      end
    end else if (copy_in) begin
      regs_q[idx_q] <= nvm[idx_q] & MASK_TAB[idx_q];
    end else if (do_write) begin
      regs_q[hit_idx] <= i_cmd.wdata & MASK_TAB[hit_idx];
    end
  end

  // store walk writes one entry per cycle; no reset, the array is the memory
  always_ff @(posedge i_sys_clk) begin
    if (state_q == ST_STORE) begin
      nvm[idx_q] <= regs_q[idx_q];
    end
  end

  // ----------------------------------------------------------------
  // answers
  // ----------------------------------------------------------------
  // anything not accepted while valid is flagged rather than silently dropped
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      refused_q <= 1'b0;
      busy_q <= 1'b1;
    end else begin
      rdata_q <= do_read ? regs_q[hit_idx] : rdata_q;
      rvalid_q <= do_read;
      refused_q <= req && !accepted;
      busy_q <= (state_d != ST_IDLE);
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
  assign o_refused = refused_q;
  assign o_busy = busy_q;

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  // limits are split into mantissa and exponent of the linear format
  assign o_cfg.operation_control = regs_q[IDX_OPERATION_CONTROL][7:0];
  assign o_cfg.on_off_source_config = regs_q[IDX_ON_OFF_SOURCE_CONFIG][7:0];
  assign o_cfg.write_lock = regs_q[IDX_WRITE_LOCK][7:0];
  assign o_cfg.sense_divider_ratio = regs_q[IDX_SENSE_DIVIDER_RATIO];
  assign o_cfg.overcurrent_fault_threshold = regs_q[IDX_OVERCURRENT_FAULT_THRESHOLD];
  assign o_cfg.overtemp_fault_threshold = regs_q[IDX_OVERTEMP_FAULT_THRESHOLD];
  assign o_cfg.overtemp_warning_threshold = regs_q[IDX_OVERTEMP_WARNING_THRESHOLD];
  assign o_cfg.soft_start_duration = regs_q[IDX_SOFT_START_DURATION][7:0];
  assign o_cfg.switching_frequency_select = regs_q[IDX_SWITCHING_FREQUENCY_SELECT][7:0];
  assign o_cfg.upper_margin_steps = regs_q[IDX_UPPER_MARGIN_STEPS];
  assign o_cfg.lower_margin_steps = regs_q[IDX_LOWER_MARGIN_STEPS];
  assign o_cfg.vendor_options = regs_q[IDX_VENDOR_OPTIONS][7:0];

endmodule : pmbus_config_nvm_bank

//--- core/pmbus_cfg_pkg.sv
// constants, tables and carrier types for the configuration register bank
package pmbus_cfg_pkg;

  // ----------------------------------------------------------------
  // register table
  // ----------------------------------------------------------------
  localparam int NUM_REGS = 12;
  localparam int IDX_W = 4;
  localparam logic [IDX_W-1:0] LAST_IDX = 4'hB;

  // command codes, one per table entry, in table order
  localparam logic [7:0] CODE_OPERATION_CONTROL = 8'h01;
  localparam logic [7:0] CODE_ON_OFF_SOURCE_CONFIG = 8'h02;
  localparam logic [7:0] CODE_WRITE_LOCK = 8'h10;
  localparam logic [7:0] CODE_SENSE_DIVIDER_RATIO = 8'h2A;
  localparam logic [7:0] CODE_OVERCURRENT_FAULT_THRESHOLD = 8'h46;
  localparam logic [7:0] CODE_OVERTEMP_FAULT_THRESHOLD = 8'h4F;
  localparam logic [7:0] CODE_OVERTEMP_WARNING_THRESHOLD = 8'h51;
  localparam logic [7:0] CODE_SOFT_START_DURATION = 8'hD1;
  localparam logic [7:0] CODE_SWITCHING_FREQUENCY_SELECT = 8'hD2;
  localparam logic [7:0] CODE_UPPER_MARGIN_STEPS = 8'hD4;
  localparam logic [7:0] CODE_LOWER_MARGIN_STEPS = 8'hD5;
  localparam logic [7:0] CODE_VENDOR_OPTIONS = 8'hDA;

  // standard bus commands that move the whole configuration
  localparam logic [7:0] CODE_STORE_ALL = 8'h11;
  localparam logic [7:0] CODE_RESTORE_ALL = 8'h12;
  localparam logic [7:0] CODE_STORE_USER_ALL = 8'h15;

  // table positions of entries the logic looks at directly
  localparam logic [IDX_W-1:0] IDX_OPERATION_CONTROL = 4'h0;
  localparam logic [IDX_W-1:0] IDX_ON_OFF_SOURCE_CONFIG = 4'h1;
  localparam logic [IDX_W-1:0] IDX_WRITE_LOCK = 4'h2;
  localparam logic [IDX_W-1:0] IDX_SENSE_DIVIDER_RATIO = 4'h3;
  localparam logic [IDX_W-1:0] IDX_OVERCURRENT_FAULT_THRESHOLD = 4'h4;
  localparam logic [IDX_W-1:0] IDX_OVERTEMP_FAULT_THRESHOLD = 4'h5;
  localparam logic [IDX_W-1:0] IDX_OVERTEMP_WARNING_THRESHOLD = 4'h6;
  localparam logic [IDX_W-1:0] IDX_SOFT_START_DURATION = 4'h7;
  localparam logic [IDX_W-1:0] IDX_SWITCHING_FREQUENCY_SELECT = 4'h8;
  localparam logic [IDX_W-1:0] IDX_UPPER_MARGIN_STEPS = 4'h9;
  localparam logic [IDX_W-1:0] IDX_LOWER_MARGIN_STEPS = 4'hA;
  localparam logic [IDX_W-1:0] IDX_VENDOR_OPTIONS = 4'hB;

  localparam logic [7:0] CODE_TAB [NUM_REGS] = '{
    CODE_OPERATION_CONTROL, CODE_ON_OFF_SOURCE_CONFIG, CODE_WRITE_LOCK,
    CODE_SENSE_DIVIDER_RATIO, CODE_OVERCURRENT_FAULT_THRESHOLD,
    CODE_OVERTEMP_FAULT_THRESHOLD, CODE_OVERTEMP_WARNING_THRESHOLD,
    CODE_SOFT_START_DURATION, CODE_SWITCHING_FREQUENCY_SELECT,
    CODE_UPPER_MARGIN_STEPS, CODE_LOWER_MARGIN_STEPS, CODE_VENDOR_OPTIONS};

  // factory default values, also the reset values of the operating registers
  localparam logic [15:0] RST_OPERATION_CONTROL = 16'h0080;
  localparam logic [15:0] RST_ON_OFF_SOURCE_CONFIG = 16'h0014;
  localparam logic [15:0] RST_WRITE_LOCK = 16'h0000;
  localparam logic [15:0] RST_SENSE_DIVIDER_RATIO = 16'hE801;
  localparam logic [15:0] RST_OVERCURRENT_FAULT_THRESHOLD = 16'h0815;
  localparam logic [15:0] RST_OVERTEMP_FAULT_THRESHOLD = 16'h101D;
  localparam logic [15:0] RST_OVERTEMP_WARNING_THRESHOLD = 16'h101A;
  localparam logic [15:0] RST_SOFT_START_DURATION = 16'h000E;
  localparam logic [15:0] RST_SWITCHING_FREQUENCY_SELECT = 16'h000C;
  localparam logic [15:0] RST_UPPER_MARGIN_STEPS = 16'h0000;
  localparam logic [15:0] RST_LOWER_MARGIN_STEPS = 16'h0000;
  localparam logic [15:0] RST_VENDOR_OPTIONS = 16'h0005;

  localparam logic [15:0] RST_TAB [NUM_REGS] = '{
    RST_OPERATION_CONTROL, RST_ON_OFF_SOURCE_CONFIG, RST_WRITE_LOCK,
    RST_SENSE_DIVIDER_RATIO, RST_OVERCURRENT_FAULT_THRESHOLD,
    RST_OVERTEMP_FAULT_THRESHOLD, RST_OVERTEMP_WARNING_THRESHOLD,
    RST_SOFT_START_DURATION, RST_SWITCHING_FREQUENCY_SELECT,
    RST_UPPER_MARGIN_STEPS, RST_LOWER_MARGIN_STEPS, RST_VENDOR_OPTIONS};

  // byte registers keep only their low eight bits
  localparam logic [15:0] MASK_BYTE = 16'h00FF;
  localparam logic [15:0] MASK_WORD = 16'hFFFF;
  localparam logic [15:0] MASK_TAB [NUM_REGS] = '{
    MASK_BYTE, MASK_BYTE, MASK_BYTE, MASK_WORD, MASK_WORD, MASK_WORD,
    MASK_WORD, MASK_BYTE, MASK_BYTE, MASK_WORD, MASK_WORD, MASK_BYTE};

  // ----------------------------------------------------------------
  // linear data field layout
  // ----------------------------------------------------------------
  localparam int LIN_MANT_LSB = 0;
  localparam int LIN_MANT_W = 11;
  localparam int LIN_EXP_LSB = 11;
  localparam int LIN_EXP_W = 5;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_LOAD,
    ST_IDLE,
    ST_STORE,
    ST_RESTORE
  } seq_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } cmd_req_s;

  typedef struct packed {
    logic signed [LIN_EXP_W-1:0] exponent;
    logic signed [LIN_MANT_W-1:0] mantissa;
  } linear_s;

  typedef struct packed {
    logic [7:0] operation_control;
    logic [7:0] on_off_source_config;
    logic [7:0] write_lock;
    logic [15:0] sense_divider_ratio;
    linear_s overcurrent_fault_threshold;
    linear_s overtemp_fault_threshold;
    linear_s overtemp_warning_threshold;
    logic [7:0] soft_start_duration;
    logic [7:0] switching_frequency_select;
    logic [15:0] upper_margin_steps;
    logic [15:0] lower_margin_steps;
    logic [7:0] vendor_options;
  } cfg_s;

endpackage : pmbus_cfg_pkg

//--- tb/pmbus_config_nvm_bank_chk.sv
// port checker for the configuration register bank
module pmbus_config_nvm_bank_chk
  import pmbus_cfg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire cmd_req_s i_cmd,
  input wire logic [15:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_refused,
  input wire logic o_busy,
  input wire cfg_s o_cfg
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // take is only a real command when the bank is idle
  wire logic take = i_cmd.valid && !o_busy;
  wire logic known = i_cmd.code inside {CODE_TAB};
  wire logic moves = i_cmd.code inside {CODE_STORE_ALL, CODE_RESTORE_ALL, CODE_STORE_USER_ALL};
  wire logic locked = o_cfg.write_lock != 8'h00;
  AST_READ_ANSWER: assert property (take && !i_cmd.write && known |=> o_rvalid && !o_refused)
    else $error("read got no answer");
  AST_BUSY_REFUSE: assert property (i_cmd.valid && o_busy |=> o_refused && !o_rvalid)
    else $error("command accepted while busy");
  AST_BAD_CODE: assert property (take && !known && !(moves && i_cmd.write) |=> o_refused)
    else $error("bad code not refused");
  AST_MOVE_WALK: assert property (take && i_cmd.write && moves |=> o_busy [*8] ##1 o_busy [*4] ##1 !o_busy)
    else $error("store or restore walk length wrong");
  AST_POWER_LOAD: assert property ($rose(i_rstn) |-> o_busy [*8] ##1 o_busy [*4] ##1 !o_busy)
    else $error("load walk after reset wrong");
  AST_LOCK_HOLDS: assert property (take && i_cmd.write && known && locked &&
    i_cmd.code != CODE_WRITE_LOCK |=> o_refused && $stable(o_cfg)) else $error("locked write changed state");
  AST_WRITE_LANDS: assert property (take && i_cmd.write && !locked &&
    i_cmd.code == CODE_SOFT_START_DURATION |=> o_cfg.soft_start_duration == $past(i_cmd.wdata[7:0]))
    else $error("write did not land");
  AST_LIMIT_READ: assert property (take && !i_cmd.write &&
    i_cmd.code == CODE_OVERCURRENT_FAULT_THRESHOLD |=> o_rdata == $past(o_cfg.overcurrent_fault_threshold))
    else $error("limit word read wrong");
  // main scenarios reached
  cover property (take && i_cmd.write && moves);
  cover property (o_refused);
  cover property (o_rvalid);
endmodule : pmbus_config_nvm_bank_chk

bind pmbus_config_nvm_bank pmbus_config_nvm_bank_chk pmbus_config_nvm_bank_chk_i (.i_sys_clk(i_sys_clk),
  .i_rstn(i_rstn), .i_cmd(i_cmd), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_refused(o_refused),
  .o_busy(o_busy), .o_cfg(o_cfg));

//--- tb/pmbus_host_model.sv
// host model issuing single commands to the register bank
module pmbus_host_model
  import pmbus_cfg_pkg::*;
(
  input wire logic i_sys_clk,
  output cmd_req_s o_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // command driver
  // ----------------------------------------------------------------
  initial o_cmd = '0;
  // one-cycle pulse; released fields flip so stale data never looks valid
  task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge i_sys_clk);
    o_cmd <= '{1'b1, w, c, d};
    @(posedge i_sys_clk);
    o_cmd <= '{1'b0, ~w, ~c, ~d};
  endtask : send
  // limit word: exponent 1 for current, 2 for temperature
  function automatic logic [15:0] lin(input logic [4:0] e, input logic [10:0] m);
    return {e, m};
  endfunction : lin
endmodule : pmbus_host_model

//--- tb/tb_pmbus_config_nvm_bank.sv
// self-checking bench for the configuration register bank
module tb_pmbus_config_nvm_bank;
  import pmbus_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  cmd_req_s i_cmd;
  logic [15:0] o_rdata;
  logic o_rvalid, o_refused, o_busy;
  cfg_s o_cfg;
  int fail_count = 0;
  int tests_run = 0;
  logic [15:0] rd;
  logic rf;
  pmbus_config_nvm_bank pmbus_config_nvm_bank_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_cmd(i_cmd),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_refused(o_refused), .o_busy(o_busy), .o_cfg(o_cfg));
  pmbus_host_model pmbus_host_model_i (.i_sys_clk(i_sys_clk), .o_cmd(i_cmd));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial forever #10 i_sys_clk = ~i_sys_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // answers stand one cycle, so catch them just after the taking edge
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
    pmbus_host_model_i.send(w, c, d);
    #1;
    rd = o_rvalid ? o_rdata : 16'hDEAD;
    rf = o_refused;
  endtask : cmd
  task automatic rdchk(input logic [7:0] c, input logic [15:0] d);
    cmd(1'b0, c, 16'h0000);
    chk(rd, d);
  endtask : rdchk
  task automatic wrchk(input logic [7:0] c, input logic [15:0] d);
    cmd(1'b1, c, d);
    chk({15'h0, rf}, 16'h0000);
  endtask : wrchk
  // bounded wait; n counts edges until busy drops
  task automatic wait_idle(output int n);
    n = 0;
    while (o_busy !== 1'b0 && n < 40) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    chk({15'h0, o_busy}, 16'h0000);
  endtask : wait_idle
  task automatic do_reset();
    int n;
    @(posedge i_sys_clk);
    i_rstn <= 1'b0;
    repeat (20) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    wait_idle(n);
  endtask : do_reset
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    for (int i = 0; i < NUM_REGS; i++) rdchk(CODE_TAB[i], RST_TAB[i]);
  endtask : t_defaults
  task automatic t_write_read();
    logic [15:0] d;
    for (int i = 0; i < NUM_REGS; i++) begin
      d = (i == 9 || i == 10) ? 16'(i - 3) : 16'hC3A0 + 16'(i);
      if (i != int'(IDX_WRITE_LOCK)) begin
        wrchk(CODE_TAB[i], d);
        rdchk(CODE_TAB[i], d & MASK_TAB[i]);
      end
    end
    wrchk(CODE_OVERCURRENT_FAULT_THRESHOLD, pmbus_host_model_i.lin(5'h01, 11'h019));
    chk({11'h0, o_cfg.overcurrent_fault_threshold.exponent}, 16'h0001);
    chk({5'h0, o_cfg.overcurrent_fault_threshold.mantissa}, 16'h0019);
    wrchk(CODE_OVERTEMP_FAULT_THRESHOLD, pmbus_host_model_i.lin(5'h02, 11'h01E));
    chk(o_cfg.overtemp_fault_threshold, 16'h101E);
    chk(o_cfg.overtemp_warning_threshold, 16'hC3A6);
  endtask : t_write_read
  task automatic t_lock();
    wrchk(CODE_WRITE_LOCK, 16'h0001);
    cmd(1'b1, CODE_SOFT_START_DURATION, 16'h0077);
    chk({15'h0, rf}, 16'h0001);
    rdchk(CODE_SOFT_START_DURATION, 16'h00A7);
    wrchk(CODE_WRITE_LOCK, 16'h0000);
    wrchk(CODE_SOFT_START_DURATION, 16'h0077);
    cmd(1'b0, 8'h00, 16'h0000);
    chk({15'h0, rf}, 16'h0001);
    cmd(1'b0, CODE_STORE_ALL, 16'h0000);
    chk({15'h0, rf}, 16'h0001);
  endtask : t_lock
  task automatic t_store();
    int n;
    cmd(1'b1, CODE_STORE_ALL, 16'h0000);
    cmd(1'b0, CODE_OPERATION_CONTROL, 16'h0000);
    chk({15'h0, rf}, 16'h0001);
    wait_idle(n);
    // twelve busy edges from the taking edge; the refused read already spent two
    chk(16'(n), 16'd10);
    wrchk(CODE_SOFT_START_DURATION, 16'h0033);
    cmd(1'b1, CODE_RESTORE_ALL, 16'h0000);
    wait_idle(n);
    chk({8'h0, o_cfg.soft_start_duration}, 16'h0077);
    wrchk(CODE_SOFT_START_DURATION, 16'h0044);
    cmd(1'b1, CODE_STORE_USER_ALL, 16'h0000);
    wait_idle(n);
    do_reset();
    rdchk(CODE_SOFT_START_DURATION, 16'h0044);
    rdchk(CODE_OPERATION_CONTROL, 16'h00A0);
  endtask : t_store
  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // the whole run needs well under a thousand cycles
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    do_reset();
    t_defaults();
    t_write_read();
    t_lock();
    t_store();
    tally_and_finish();
  end
endmodule : tb_pmbus_config_nvm_bank
